//--- src/pfcps_pkg.sv
package pfcps_pkg;
	localparam int unsigned CLK_HZ = 200000000;
	localparam int unsigned CLK_PERIOD_NS = 5;
	localparam int unsigned NS_PER_US = 1000;
	localparam logic [7:0] US_CYCLES = 8'(NS_PER_US / CLK_PERIOD_NS);
	localparam int unsigned MS_TICK_US_DEF = 1000;
	localparam int unsigned RESTART_STEP_MS = 500;
	localparam int unsigned RESTART_MAX_MS = 10000;
	localparam int unsigned FLR_STEP_MS = 500;
	localparam int unsigned FLR_MAX_MS = 10000;
	localparam int unsigned BOD_STEP_MS = 50;
	localparam int unsigned BOD_MAX_MS = 1200;
	localparam logic [16:0] CNT_CLEAR_MS = 17'd65000;
	localparam int unsigned AUX_FILTER_NS = 1000;
	localparam int unsigned MIN_FREQ_DEF_HZ = 40000;
	localparam logic [15:0] TON_MAX_DEF = 16'(CLK_HZ / MIN_FREQ_DEF_HZ);
	localparam int unsigned MIN_OFF_NS [4] = '{500, 750, 1000, 1500};
	localparam int unsigned VTO_NS [4] = '{2000, 3000, 7000, 7000};
	localparam int unsigned VCC_DLY_US [6] = '{10, 50, 100, 500, 5000, 10000};
	localparam logic [2:0] VCC_DLY_N = 3'h6;
	localparam int unsigned SHORT_CYC [4] = '{500, 2500, 5000, 12500};
	localparam logic [2:0] SHORT_N = 3'h4;

	localparam logic [7:0] ADDR_TIMING = 8'h00;
	localparam logic [7:0] ADDR_LEVELS = 8'h04;
	localparam logic [7:0] ADDR_MODES = 8'h08;
	localparam logic [7:0] ADDR_GATE = 8'h0c;
	localparam logic [7:0] ADDR_STATUS = 8'h10;
	localparam logic [7:0] ADDR_CAUSE = 8'h14;

	localparam int unsigned SRC_VCC = 0;
	localparam int unsigned SRC_OTP = 1;
	localparam int unsigned SRC_AUX = 2;
	localparam int unsigned SRC_COIL = 3;
	localparam int unsigned SRC_DIODE = 4;
	localparam int unsigned SRC_N = 5;

	function automatic int unsigned ns_to_cyc(int unsigned ns);
		return (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	endfunction

	function automatic logic [16:0] scaled_ms(int unsigned step, int unsigned max, int unsigned mult);
		int unsigned v;
		v = step * mult;
		if (v > max) begin
			v = max;
		end
		return 17'(v);
	endfunction

	typedef enum logic [1:0] {
		PM_OFF = 2'h0,
		PM_LATCH = 2'h1,
		PM_RESTART = 2'h2,
		PM_LATCH_AFTER = 2'h3
	} pfcps_mode_t;

	typedef enum logic [2:0] {
		PS_RUN = 3'b001,
		PS_RESTART = 3'b010,
		PS_LATCHED = 3'b100
	} pfcps_pstate_t;

	typedef struct packed {
		logic mains_above_bi;
		logic mains_above_bo;
		logic boost_stop;
		logic boost_start;
		logic boost_ovp;
		logic boost_below_reg;
		logic vcc_ovp;
		logic vcc_imm;
		logic vcc_below_rst;
		logic otp_int;
		logic otp_ext;
		logic cs_ocp_two;
		logic cs_ocp_single;
		logic src_ocp;
		logic aux_ovp;
		logic demag;
		logic valley;
	} pfcps_sense_t;

	typedef struct packed {
		logic [10:0] rsv2;
		logic [4:0] bod_sel;
		logic [2:0] rsv1;
		logic [4:0] flr_sel;
		logic [2:0] rsv0;
		logic [4:0] restart_sel;
	} pfcps_timing_t;

	typedef struct packed {
		logic [15:0] rsv;
		logic [1:0] aux_ovp_level;
		logic [1:0] boost_ovp_level;
		logic [3:0] vcc_ovp_level;
		logic [3:0] brownout_hysteresis;
		logic [3:0] brown_in_threshold;
	} pfcps_levels_t;

	typedef struct packed {
		logic [7:0] rsv1;
		logic [3:0] restart_limit;
		logic [2:0] diode_sel;
		logic [2:0] coil_sel;
		pfcps_mode_t short_mode;
		pfcps_mode_t aux_mode;
		pfcps_mode_t otp_mode;
		pfcps_mode_t vcc_mode;
		logic [2:0] vcc_delay_sel;
		logic [2:0] rsv0;
	} pfcps_modes_t;

	typedef struct packed {
		logic [11:0] min_stroke;
		logic [1:0] valley_to_sel;
		logic [1:0] min_off_sel;
		logic [15:0] ton_max;
	} pfcps_gate_t;

	typedef struct packed {
		logic [19:0] rsv;
		logic [3:0] restart_cnt;
		pfcps_pstate_t state;
		logic boost_ovp_hold;
		logic fast_disable;
		logic brownout;
		logic sw_enable;
		logic gate;
	} pfcps_status_t;

	localparam pfcps_timing_t TIMING_RST = '{rsv2: '0, bod_sel: 5'h00, rsv1: '0, flr_sel: 5'h02, rsv0: '0,
		restart_sel: 5'h01};
	localparam pfcps_levels_t LEVELS_RST = '{rsv: '0, aux_ovp_level: 2'h0, boost_ovp_level: 2'h1,
		vcc_ovp_level: 4'he, brownout_hysteresis: 4'h0, brown_in_threshold: 4'h0};
	localparam pfcps_modes_t MODES_RST = '{rsv1: '0, restart_limit: 4'h4, diode_sel: 3'h0, coil_sel: 3'h0,
		short_mode: PM_RESTART, aux_mode: PM_RESTART, otp_mode: PM_RESTART, vcc_mode: PM_RESTART,
		vcc_delay_sel: 3'h6, rsv0: '0};
	localparam pfcps_gate_t GATE_RST = '{min_stroke: 12'h000, valley_to_sel: 2'h0, min_off_sel: 2'h0,
		ton_max: TON_MAX_DEF};
endpackage

//--- src/pfcps_top.sv
// Our own choices: strobed register access and the placing of the registers.
`timescale 1ns/1ps
// Notes on behaviour
// - Safe-restart protections resume after one shared delay, 0.5 s to 10 s.
// - Mains absent for programmed 0-10 s, timed from mains falling below brownout level, clears all protections once in brownout.
// - After that clear, restart only once mains exceeds brown-in again.
// - Boost stop comparator halts switching; start comparator resumes it.
// - Brown-in level 67-185 V and hysteresis 2-17 V are configurable selections.
// - Brownout entered only after mains stays low for 50 ms to 1.2 s.
// - Supply overvoltage level configurable 10-25 V in 1 V steps.
// - Supply overvoltage fires after selected delay 10 us-10 ms, or disabled.
// - Supply above fixed 25 V fires overvoltage at once, no delay.
// - Internal overtemperature uses the external overtemperature response mode.
// - Overcurrent uses two-phase threshold, or single-phase threshold when shedding.
// - Gate on-time ends within one minimum-frequency period.
// - Current-sense overcurrent every cycle for selected count enters protection.
// - Source-sense overcurrent every cycle for selected count enters protection.
// - Boost overvoltage threshold selectable among four settings.
// - Boost overvoltage stops switching; resumes below regulation level, no delay.
// - Aux overvoltage threshold selectable among four; detection is filtered.
// - Aux overvoltage response latched, restart, latch-after-restart, or disabled.
// - Valley wait after demagnetization ends at selectable 2, 3 or 7 us.
// - Gate held low at least selected minimum off-time 500-1500 ns.
// - Demagnetization and valley ignored until minimum stroke after turn-off.
// - Latched protection holds until fast latch reset or supply reset level.
// - Latch-after-restart counts triggers, latches at limit, clears after 65 s quiet.
module pfcps_top #(
	parameter int unsigned MS_TICK_US = pfcps_pkg::MS_TICK_US_DEF
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [31:0] rdata,
	input wire pfcps_pkg::pfcps_sense_t sense_in,
	input wire logic phase_single,
	input wire logic on_req,
	input wire logic on_done,
	output logic gate_out,
	output logic sw_enable,
	output logic protection_active,
	output logic latched,
	output logic brownout,
	output pfcps_pkg::pfcps_levels_t level_cfg
);
	import pfcps_pkg::*;

	pfcps_sense_t s1_reg, s2_reg, s3_reg, s;
	pfcps_timing_t tim_reg;
	pfcps_levels_t lvl_reg;
	pfcps_modes_t mod_reg;
	pfcps_gate_t gat_reg;
	pfcps_pstate_t state_reg;
	pfcps_status_t status;
	logic [SRC_N-1:0] cause_reg, trig, fired;
	pfcps_mode_t src_mode [SRC_N];
	logic [7:0] us_cnt_reg;
	logic [15:0] ms_cnt_reg;
	logic us_tick_reg, ms_tick_reg;
	logic [16:0] low_ms_reg, rs_ms_reg, quiet_ms_reg;
	logic brownout_reg, flr_done_reg, flr_clear;
	logic fast_dis_reg, bovp_hold_reg, sw_en_reg, gate_reg;
	logic [13:0] vcc_cnt_reg, coil_cnt_reg, diode_cnt_reg;
	logic [13:0] vcc_lim;
	logic [7:0] aux_cnt_reg;
	logic [3:0] restart_cnt_reg;
	logic any_fire, any_latch, any_after, after_lim;
	logic [15:0] on_cnt_reg;
	logic [11:0] off_cnt_reg, vto_cnt_reg;
	logic demag_seen_reg, valley_hit_reg, cs_flag_reg, src_flag_reg;
	logic ocp_now, stroke_ok, turn_off, turn_on;
	logic [31:0] rd_word;

	localparam logic [7:0] AUX_FILT = 8'(ns_to_cyc(AUX_FILTER_NS));

	function automatic logic [13:0] short_lim(logic [2:0] sel);
		return 14'(SHORT_CYC[sel[1:0]]);
	endfunction

	// Input synchroniser; a change counts once stages two and three agree
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_reg <= '0;
			s2_reg <= '0;
			s3_reg <= '0;
			s <= '0;
		end else begin
			s1_reg <= sense_in;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			s <= (s2_reg & s3_reg) | (s & (s2_reg ^ s3_reg));
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			us_cnt_reg <= '0;
			ms_cnt_reg <= '0;
			us_tick_reg <= 1'b0;
			ms_tick_reg <= 1'b0;
		end else begin
			us_tick_reg <= (us_cnt_reg == US_CYCLES - 8'h01);
			us_cnt_reg <= (us_cnt_reg == US_CYCLES - 8'h01) ? '0 : us_cnt_reg + 8'h01;
			ms_tick_reg <= us_tick_reg && (ms_cnt_reg == 16'(MS_TICK_US - 1));
			if (us_tick_reg) begin
				ms_cnt_reg <= (ms_cnt_reg == 16'(MS_TICK_US - 1)) ? '0 : ms_cnt_reg + 16'h0001;
			end
		end
	end

	// Register writes
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tim_reg <= TIMING_RST;
			lvl_reg <= LEVELS_RST;
			mod_reg <= MODES_RST;
			gat_reg <= GATE_RST;
		end else if (wr_en) begin
			unique case (addr)
				ADDR_TIMING: begin
					tim_reg <= wdata;
					tim_reg.rsv0 <= '0;
					tim_reg.rsv1 <= '0;
					tim_reg.rsv2 <= '0;
				end
				ADDR_LEVELS: begin
					lvl_reg <= wdata;
					lvl_reg.rsv <= '0;
				end
				ADDR_MODES: begin
					mod_reg <= wdata;
					mod_reg.rsv0 <= '0;
					mod_reg.rsv1 <= '0;
				end
				ADDR_GATE: gat_reg <= wdata;
				default: ;
			endcase
		end
	end

	always_comb begin
		status = '0;
		status.restart_cnt = restart_cnt_reg;
		status.state = state_reg;
		status.boost_ovp_hold = bovp_hold_reg;
		status.fast_disable = fast_dis_reg;
		status.brownout = brownout_reg;
		status.sw_enable = sw_en_reg;
		status.gate = gate_reg;
		unique case (addr)
			ADDR_TIMING: rd_word = tim_reg;
			ADDR_LEVELS: rd_word = lvl_reg;
			ADDR_MODES: rd_word = mod_reg;
			ADDR_GATE: rd_word = gat_reg;
			ADDR_STATUS: rd_word = status;
			ADDR_CAUSE: rd_word = 32'(cause_reg);
			default: rd_word = '0;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata <= '0;
		end else begin
			rdata <= rd_en ? rd_word : '0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			level_cfg <= LEVELS_RST;
		end else begin
			level_cfg <= lvl_reg;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			low_ms_reg <= '0;
			brownout_reg <= 1'b0;
			flr_done_reg <= 1'b0;
		end else begin
			if (!s.mains_above_bo || brownout_reg) begin
				if (ms_tick_reg && low_ms_reg != '1) begin
					low_ms_reg <= low_ms_reg + 17'h00001;
				end
			end else begin
				low_ms_reg <= '0;
			end
			if (brownout_reg && s.mains_above_bi) begin
				brownout_reg <= 1'b0;
				flr_done_reg <= 1'b0;
			end else if (!s.mains_above_bo && low_ms_reg >= scaled_ms(BOD_STEP_MS, BOD_MAX_MS,
				32'(tim_reg.bod_sel) + 1)) begin
				brownout_reg <= 1'b1;
			end
			if (flr_clear) begin
				flr_done_reg <= 1'b1;
			end
		end
	end

	// fast latch reset once mains absent long enough
	assign flr_clear = brownout_reg && !flr_done_reg &&
		(low_ms_reg >= scaled_ms(FLR_STEP_MS, FLR_MAX_MS, 32'(tim_reg.flr_sel)));

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			fast_dis_reg <= 1'b0;
			bovp_hold_reg <= 1'b0;
		end else begin
			if (s.boost_stop) begin
				fast_dis_reg <= 1'b1;
			end else if (s.boost_start) begin
				fast_dis_reg <= 1'b0;
			end
			if (s.boost_ovp) begin
				bovp_hold_reg <= 1'b1;
			end else if (s.boost_below_reg) begin
				bovp_hold_reg <= 1'b0;
			end
		end
	end

	assign vcc_lim = 14'(VCC_DLY_US[(mod_reg.vcc_delay_sel < VCC_DLY_N) ? mod_reg.vcc_delay_sel : 3'h0]);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			vcc_cnt_reg <= '0;
			aux_cnt_reg <= '0;
		end else begin
			if (!s.vcc_ovp || mod_reg.vcc_delay_sel >= VCC_DLY_N) begin
				vcc_cnt_reg <= '0;
			end else if (us_tick_reg && vcc_cnt_reg <= vcc_lim) begin
				vcc_cnt_reg <= vcc_cnt_reg + 14'h0001;
			end
			if (!s.aux_ovp) begin
				aux_cnt_reg <= '0;
			end else if (aux_cnt_reg < AUX_FILT) begin
				aux_cnt_reg <= aux_cnt_reg + 8'h01;
			end
		end
	end

	always_comb begin
		trig[SRC_VCC] = s.vcc_imm || (mod_reg.vcc_delay_sel < VCC_DLY_N && vcc_cnt_reg > vcc_lim);
		// internal and external overtemperature share one mode
		trig[SRC_OTP] = s.otp_int || s.otp_ext;
		trig[SRC_AUX] = (aux_cnt_reg == AUX_FILT);
		trig[SRC_COIL] = mod_reg.coil_sel < SHORT_N && coil_cnt_reg >= short_lim(mod_reg.coil_sel);
		trig[SRC_DIODE] = mod_reg.diode_sel < SHORT_N && diode_cnt_reg >= short_lim(mod_reg.diode_sel);
		src_mode[SRC_VCC] = (s.vcc_imm && mod_reg.vcc_mode == PM_OFF) ? PM_RESTART : mod_reg.vcc_mode;
		src_mode[SRC_OTP] = mod_reg.otp_mode;
		src_mode[SRC_AUX] = mod_reg.aux_mode;
		src_mode[SRC_COIL] = mod_reg.short_mode;
		src_mode[SRC_DIODE] = mod_reg.short_mode;
		fired = '0;
		any_latch = 1'b0;
		any_after = 1'b0;
		for (int i = 0; i < SRC_N; i++) begin
			if (trig[i] && src_mode[i] != PM_OFF && state_reg == PS_RUN) begin
				fired[i] = 1'b1;
				any_latch = any_latch || (src_mode[i] == PM_LATCH);
				any_after = any_after || (src_mode[i] == PM_LATCH_AFTER);
			end
		end
		any_fire = |fired;
		after_lim = any_after && ({1'b0, restart_cnt_reg} + 5'h01 >= {1'b0, mod_reg.restart_limit});
	end

	// Protection state
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= PS_RUN;
		end else if (flr_clear || (state_reg == PS_LATCHED && s.vcc_below_rst)) begin
			state_reg <= PS_RUN;
		end else begin
			unique case (state_reg)
				PS_RUN: begin
					if (any_fire) begin
						state_reg <= (any_latch || after_lim) ? PS_LATCHED : PS_RESTART;
					end
				end
				PS_RESTART: begin
					if (rs_ms_reg >= scaled_ms(RESTART_STEP_MS, RESTART_MAX_MS, 32'(tim_reg.restart_sel) + 1)) begin
						state_reg <= PS_RUN;
					end
				end
				PS_LATCHED: ;
				default: state_reg <= PS_RUN;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			restart_cnt_reg <= '0;
			quiet_ms_reg <= '0;
			rs_ms_reg <= '0;
			cause_reg <= '0;
		end else begin
			if (state_reg == PS_RESTART) begin
				rs_ms_reg <= rs_ms_reg + 17'(ms_tick_reg);
			end else begin
				rs_ms_reg <= '0;
			end
			if (any_after) begin
				quiet_ms_reg <= '0;
			end else if (ms_tick_reg && quiet_ms_reg < CNT_CLEAR_MS) begin
				quiet_ms_reg <= quiet_ms_reg + 17'h00001;
			end
			if (flr_clear || (!any_after && quiet_ms_reg >= CNT_CLEAR_MS)) begin
				restart_cnt_reg <= '0;
			end else if (any_after && restart_cnt_reg != '1) begin
				restart_cnt_reg <= restart_cnt_reg + 4'h1;
			end
			cause_reg <= ((flr_clear ? '0 : cause_reg) &
				~((wr_en && addr == ADDR_CAUSE) ? wdata[SRC_N-1:0] : '0)) | fired;
		end
	end

	assign ocp_now = phase_single ? s.cs_ocp_single : s.cs_ocp_two;
	// minimum stroke before demag and valley count
	assign stroke_ok = off_cnt_reg >= gat_reg.min_stroke;
	assign turn_off = gate_reg && (on_done || ocp_now || s.src_ocp || !sw_en_reg ||
		on_cnt_reg + 16'h0001 >= gat_reg.ton_max);
	assign turn_on = !gate_reg && sw_en_reg && on_req && stroke_ok &&
		off_cnt_reg >= 12'(ns_to_cyc(MIN_OFF_NS[gat_reg.min_off_sel])) &&
		(valley_hit_reg || vto_cnt_reg >= 12'(ns_to_cyc(VTO_NS[gat_reg.valley_to_sel])));

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sw_en_reg <= 1'b0;
			gate_reg <= 1'b0;
			on_cnt_reg <= '0;
			off_cnt_reg <= '0;
			vto_cnt_reg <= '0;
			demag_seen_reg <= 1'b0;
			valley_hit_reg <= 1'b0;
		end else begin
			sw_en_reg <= state_reg == PS_RUN && !any_fire && !brownout_reg && !fast_dis_reg && !bovp_hold_reg;
			if (turn_off) begin
				gate_reg <= 1'b0;
				off_cnt_reg <= '0;
				vto_cnt_reg <= '0;
				demag_seen_reg <= 1'b0;
				valley_hit_reg <= 1'b0;
			end else if (turn_on) begin
				gate_reg <= 1'b1;
				on_cnt_reg <= '0;
			end else if (gate_reg) begin
				on_cnt_reg <= on_cnt_reg + 16'h0001;
			end else begin
				off_cnt_reg <= (off_cnt_reg == '1) ? off_cnt_reg : off_cnt_reg + 12'h001;
				if (stroke_ok && s.demag) begin
					demag_seen_reg <= 1'b1;
				end
				if (demag_seen_reg && vto_cnt_reg != '1) begin
					vto_cnt_reg <= vto_cnt_reg + 12'h001;
				end
				if (stroke_ok && demag_seen_reg && s.valley) begin
					valley_hit_reg <= 1'b1;
				end
			end
		end
	end

	// Consecutive overcurrent cycle counters
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cs_flag_reg <= 1'b0;
			src_flag_reg <= 1'b0;
			coil_cnt_reg <= '0;
			diode_cnt_reg <= '0;
		end else if (state_reg != PS_RUN) begin
			cs_flag_reg <= 1'b0;
			src_flag_reg <= 1'b0;
			coil_cnt_reg <= '0;
			diode_cnt_reg <= '0;
		end else if (turn_on) begin
			cs_flag_reg <= 1'b0;
			src_flag_reg <= 1'b0;
			coil_cnt_reg <= cs_flag_reg ? coil_cnt_reg + 14'h0001 : '0;
			diode_cnt_reg <= src_flag_reg ? diode_cnt_reg + 14'h0001 : '0;
		end else if (gate_reg) begin
			cs_flag_reg <= cs_flag_reg || ocp_now;
			src_flag_reg <= src_flag_reg || s.src_ocp;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			gate_out <= 1'b0;
			sw_enable <= 1'b0;
			protection_active <= 1'b0;
			latched <= 1'b0;
			brownout <= 1'b0;
		end else begin
			gate_out <= gate_reg && !turn_off;
			sw_enable <= sw_en_reg;
			protection_active <= state_reg != PS_RUN;
			latched <= state_reg == PS_LATCHED;
			brownout <= brownout_reg;
		end
	end
endmodule

//--- testbench/pfcps_plant.sv
`timescale 1ns/1ps
module pfcps_plant (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic gate_out,
	input wire pfcps_pkg::pfcps_sense_t cmd,
	input wire logic [15:0] ton_req,
	input wire logic no_valley,
	output pfcps_pkg::pfcps_sense_t sense_in,
	output logic on_req,
	output logic on_done
);
	import pfcps_pkg::*;
	logic gate_reg;
	logic [15:0] cnt_reg;
	// Cycles since the gate last changed
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			gate_reg <= 1'b0;
			cnt_reg <= 16'h0000;
		end else begin
			gate_reg <= gate_out;
			if (gate_out != gate_reg) begin
				cnt_reg <= 16'h0000;
			end else if (cnt_reg != 16'hffff) begin
				cnt_reg <= cnt_reg + 16'h0001;
			end
		end
	end
	// Ringing after turn-off, current ramp while on
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sense_in <= '0;
			on_req <= 1'b0;
			on_done <= 1'b0;
		end else begin
			sense_in <= cmd;
			sense_in.demag <= !gate_out && !gate_reg && cnt_reg >= 16'h0014;
			sense_in.valley <= !gate_out && !gate_reg && !no_valley && cnt_reg >= 16'h001e;
			sense_in.cs_ocp_two <= cmd.cs_ocp_two && gate_reg && cnt_reg >= 16'h0002;
			sense_in.cs_ocp_single <= cmd.cs_ocp_single && gate_reg && cnt_reg >= 16'h0002;
			sense_in.src_ocp <= cmd.src_ocp && gate_reg && cnt_reg >= 16'h0002;
			on_req <= !gate_out;
			on_done <= gate_reg && ton_req != 16'h0000 && cnt_reg >= ton_req;
		end
	end
endmodule

//--- testbench/pfcps_asserts.sv
`timescale 1ns/1ps
module pfcps_checker #(
	parameter int unsigned MS_TICK_US = 1000
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic rd_en,
	input wire logic [31:0] rdata,
	input wire pfcps_pkg::pfcps_sense_t sense_in,
	input wire logic gate_out,
	input wire logic sw_enable,
	input wire logic protection_active,
	input wire logic latched,
	input wire logic brownout
);
	import pfcps_pkg::*;
	localparam int unsigned BO_MIN = 49 * MS_TICK_US * US_CYCLES;
	logic [16:0] hi_cnt;
	logic [8:0] lo_cnt;
	logic hi_seen;
	logic [31:0] mains_low;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			hi_cnt <= 17'h00000;
			lo_cnt <= 9'h000;
			hi_seen <= 1'b0;
			mains_low <= 32'h00000000;
		end else begin
			hi_cnt <= gate_out ? hi_cnt + 17'h00001 : 17'h00000;
			lo_cnt <= gate_out ? 9'h000 : lo_cnt + {8'h00, lo_cnt != 9'h1ff};
			hi_seen <= hi_seen | gate_out;
			mains_low <= sense_in.mains_above_bo ? 32'h00000000 : mains_low + 32'h00000001;
		end
	end
	property p_rdata_idle;
		!$past(rd_en) |-> rdata == 32'h00000000;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero outside read cycle");
	property p_latch_prot;
		latched |-> protection_active;
	endproperty
	a_latch_prot: assert property (p_latch_prot) else $error("latched without protection state");
	property p_prot_gate;
		protection_active [*3] |-> !gate_out && !sw_enable;
	endproperty
	a_prot_gate: assert property (p_prot_gate) else $error("switching during protection");
	property p_brown_sw;
		brownout [*2] |-> !sw_enable;
	endproperty
	a_brown_sw: assert property (p_brown_sw) else $error("switching in brownout");
	property p_stop_sw;
		sense_in.boost_stop [*8] |-> !sw_enable;
	endproperty
	a_stop_sw: assert property (p_stop_sw) else $error("switching below stop level");
	property p_vcc_imm;
		(!protection_active && !sense_in.vcc_imm) ##1 sense_in.vcc_imm [*8] |-> protection_active;
	endproperty
	a_vcc_imm: assert property (p_vcc_imm) else $error("immediate supply trip delayed");
	property p_bo_delay;
		$rose(brownout) |-> mains_low >= BO_MIN;
	endproperty
	a_bo_delay: assert property (p_bo_delay) else $error("brownout before detect time");
	property p_min_off;
		$rose(gate_out) && hi_seen |-> lo_cnt >= 9'h064;
	endproperty
	a_min_off: assert property (p_min_off) else $error("gate off time too short");
	property p_ton;
		gate_out |-> hi_cnt <= 17'h10001;
	endproperty
	a_ton: assert property (p_ton) else $error("gate on time beyond limit");
	c_latch: cover property ($rose(latched));
	c_brown_in: cover property ($fell(brownout));
	c_gate: cover property ($rose(gate_out));
endmodule
bind pfcps_top pfcps_checker #(.MS_TICK_US(MS_TICK_US)) pfcps_checker_i (.clk(clk), .rst_n(rst_n),
	.rd_en(rd_en), .rdata(rdata), .sense_in(sense_in), .gate_out(gate_out), .sw_enable(sw_enable),
	.protection_active(protection_active), .latched(latched), .brownout(brownout));

//--- testbench/tb.sv
`timescale 1ns/1ps
module tb;
	import pfcps_pkg::*;
	typedef struct packed {
		logic wr;
		logic [7:0] a;
		logic [31:0] d;
		logic [31:0] e;
	} pfcps_row_t;
	typedef struct packed {
		logic [31:0] g;
		logic [15:0] ton;
		logic nv;
		logic [15:0] hmax;
		logic [15:0] lmin;
	} pfcps_grow_t;
	localparam pfcps_row_t ROWS [8] = '{
		'{1'b0, 8'h00, 32'h0, 32'h00000201},
		'{1'b0, 8'h04, 32'h0, 32'h00001e00},
		'{1'b0, 8'h08, 32'h0, 32'h00402ab0},
		'{1'b0, 8'h0c, 32'h0, 32'h00001388},
		'{1'b0, 8'h14, 32'h0, 32'h00000000},
		'{1'b1, 8'h00, 32'hffffffff, 32'h001f1f1f},
		'{1'b1, 8'h20, 32'hffffffff, 32'h00000000},
		'{1'b1, 8'h04, 32'h0000a5c3, 32'h0000a5c3}};
	localparam pfcps_grow_t GROWS [5] = '{
		'{32'h00010028, 16'h0000, 1'b0, 16'h002a, 16'h0096},
		'{32'h00031388, 16'h000a, 1'b0, 16'h0010, 16'h012c},
		'{32'h00001388, 16'h000a, 1'b1, 16'h0010, 16'h01a4},
		'{32'h00081388, 16'h000a, 1'b1, 16'h0010, 16'h058c},
		'{32'h25801388, 16'h000a, 1'b0, 16'h0010, 16'h0258}};
	logic clk;
	logic rst_n;
	logic [7:0] addr;
	logic [31:0] wdata;
	logic wr_en;
	logic rd_en;
	logic [31:0] rdata;
	pfcps_sense_t cmd;
	pfcps_sense_t sense_in;
	logic phase_single;
	logic on_req;
	logic on_done;
	logic gate_out;
	logic sw_enable;
	logic protection_active;
	logic latched;
	logic brownout;
	pfcps_levels_t level_cfg;
	logic [15:0] ton_req;
	logic no_valley;
	logic gate_q;
	int fails = 0;
	int samples_checked = 0;
	int cycles = 0;
	int rises = 0;
	int hi_len = 0;
	int lo_len = 0;
	int hi_max = 0;
	int lo_min = 0;
	pfcps_top #(.MS_TICK_US(1)) pfcps_top_i (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
		.wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .sense_in(sense_in), .phase_single(phase_single),
		.on_req(on_req), .on_done(on_done), .gate_out(gate_out), .sw_enable(sw_enable),
		.protection_active(protection_active), .latched(latched), .brownout(brownout), .level_cfg(level_cfg));
	pfcps_plant pfcps_plant_i (.clk(clk), .rst_n(rst_n), .gate_out(gate_out), .cmd(cmd), .ton_req(ton_req),
		.no_valley(no_valley), .sense_in(sense_in), .on_req(on_req), .on_done(on_done));
	task automatic end_of_test();
		$display("checked %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic ck(string nm, logic [31:0] e, logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic ck1(string nm, logic c);
		ck(nm, 32'h00000001, {31'h0, c});
	endtask
	task automatic cyc(int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic wr(logic [7:0] a, logic [31:0] d);
		@(posedge clk);
		wr_en <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr_en <= 1'b0;
	endtask
	task automatic rd(logic [7:0] a, string nm, logic [31:0] e);
		@(posedge clk);
		rd_en <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd_en <= 1'b0;
		#1;
		ck(nm, e, rdata);
	endtask
	task automatic clr();
		rises = 0;
		hi_max = 0;
		lo_min = 100000;
	endtask
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// Gate pulse statistics
	always @(posedge clk) begin
		cycles++;
		if (cycles == 110000) begin
			fails++;
			$display("[ERR] run_length expected 110000 seen more");
			end_of_test();
		end
		if (gate_out && !gate_q) begin
			if (rises > 0 && lo_len < lo_min) begin
				lo_min = lo_len;
			end
			rises++;
			hi_len = 0;
		end
		if (!gate_out && gate_q) begin
			if (rises > 0 && hi_len > hi_max) begin
				hi_max = hi_len;
			end
			lo_len = 0;
		end
		if (gate_out) begin
			hi_len++;
		end else begin
			lo_len++;
		end
		gate_q = gate_out;
	end
	initial begin
		rst_n = 1'b0;
		addr = 8'h00;
		wdata = 32'h0;
		wr_en = 1'b0;
		rd_en = 1'b0;
		phase_single = 1'b0;
		ton_req = 16'h000a;
		no_valley = 1'b0;
		gate_q = 1'b0;
		cmd = '0;
		cmd.mains_above_bi = 1'b1;
		cmd.mains_above_bo = 1'b1;
		cmd.boost_start = 1'b1;
		cmd.boost_below_reg = 1'b1;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		foreach (ROWS[i]) begin
			if (ROWS[i].wr) begin
				wr(ROWS[i].a, ROWS[i].d);
			end
			rd(ROWS[i].a, "reg_row", ROWS[i].e);
		end
		ck("level_cfg", 32'h0000a5c3, level_cfg);
		wr(ADDR_TIMING, 32'h00000000);
		$display("test registers done");
		foreach (GROWS[i]) begin
			wr(ADDR_GATE, GROWS[i].g);
			ton_req <= GROWS[i].ton;
			no_valley <= GROWS[i].nv;
			clr();
			cyc(5000);
			ck1("pulses", rises > 2);
			ck1("on_time", hi_max <= GROWS[i].hmax);
			ck1("off_time", lo_min >= GROWS[i].lmin && lo_min <= GROWS[i].lmin + 20);
		end
		$display("test gate done");
		@(posedge clk) cmd.boost_stop <= 1'b1;
		cmd.boost_start <= 1'b0;
		cyc(12);
		ck1("fast_stop", !sw_enable && !gate_out);
		@(posedge clk) cmd.boost_stop <= 1'b0;
		cyc(12);
		ck1("between_levels", !sw_enable);
		@(posedge clk) cmd.boost_start <= 1'b1;
		cyc(12);
		ck1("fast_start", sw_enable);
		@(posedge clk) cmd.boost_ovp <= 1'b1;
		cmd.boost_below_reg <= 1'b0;
		cyc(12);
		ck1("ovp_stop", !sw_enable);
		@(posedge clk) cmd.boost_ovp <= 1'b0;
		cyc(12);
		ck1("ovp_hold", !sw_enable);
		@(posedge clk) cmd.boost_below_reg <= 1'b1;
		cyc(12);
		ck1("ovp_resume", sw_enable && !protection_active);
		$display("test boost done");
		wr(ADDR_MODES, 32'h00481970);
		@(posedge clk) cmd.vcc_imm <= 1'b1;
		cyc(10);
		ck1("vcc_fast", protection_active && latched);
		@(posedge clk) cmd.vcc_imm <= 1'b0;
		cyc(500);
		ck1("latch_hold", latched && !gate_out && !sw_enable);
		rd(ADDR_CAUSE, "cause", 32'h00000001);
		wr(ADDR_CAUSE, 32'h00000001);
		rd(ADDR_CAUSE, "cause_clear", 32'h00000000);
		@(posedge clk) cmd.vcc_below_rst <= 1'b1;
		cyc(12);
		ck1("latch_release", !latched && !protection_active);
		@(posedge clk) cmd.vcc_below_rst <= 1'b0;
		$display("test supply done");
		wr(ADDR_GATE, 32'h00001388);
		ton_req <= 16'h0000;
		phase_single <= 1'b1;
		cmd.cs_ocp_single <= 1'b1;
		clr();
		repeat (70000) if (!protection_active) @(posedge clk);
		ck1("coil_count", latched && rises >= 499 && rises <= 502);
		@(posedge clk) cmd.cs_ocp_single <= 1'b0;
		$display("test coil done");
		@(posedge clk) cmd.mains_above_bi <= 1'b0;
		cmd.mains_above_bo <= 1'b0;
		cyc(9500);
		ck1("bo_early", !brownout);
		cyc(1000);
		ck1("bo_clear", brownout && !latched && !protection_active && !sw_enable);
		@(posedge clk) cmd.mains_above_bi <= 1'b1;
		cmd.mains_above_bo <= 1'b1;
		cyc(20);
		ck1("brown_in", !brownout && sw_enable);
		$display("test mains done");
		@(posedge clk) cmd.otp_int <= 1'b1;
		cyc(12);
		ck1("otp_mode", protection_active && latched);
		$display("test otp done");
		end_of_test();
	end
endmodule
